// >>> hdl/tiss_top.sv
`timescale 1ns/100ps

// Function
// - Warn flag sets: stamped frame, entry held
// - Warn flag clears outside operation or disabled
// - Update flag sets: stamped frame, fifo enabled
// - Update flag clears: mode, disable, release
// - Stamp flags clear on zero, ignore ones
// - Queue flag sets when frame sent
// - Queue flags clear on leaving operation
// - Queue flags clear on zero, ignore ones
// - Queue flag marks end of link transmission
// - Reserved status bits read as zero
// - Descriptor summary is enable and flag
// - Queue interrupt while enable and flag
// - Warn interrupt when warn flag enabled
// - Warn summary is enable and flag
// - Update summary is enable and flag
module tiss_top
  import tiss_pkg::*;
(
  input  wire logic                  mclk,
  input  wire logic                  resetn,
  input  wire tiss_pkg::tiss_bus_req_t bus_req,
  output logic [tiss_pkg::DATA_W-1:0] bus_rdata,
  input  wire logic                  op_mode,
  input  wire tiss_pkg::tiss_ts_evt_t ts_evt,
  input  wire logic [tiss_pkg::NQ-1:0] frame_sent,
  input  wire tiss_pkg::tiss_desc_t   desc_in,
  output logic [tiss_pkg::NQ-1:0]     frame_sent_irq,
  output logic                        ts_warn_irq,
  output logic                        ts_update_irq,
  output logic                        irq
);
  import tiss_pkg::*;

  logic              op_mode_reg;
  logic              ts_fifo_warn_flag_reg;
  logic              ts_fifo_warn_flag_next;
  logic              ts_fifo_update_flag_reg;
  logic              ts_fifo_update_flag_next;
  logic [NQ-1:0]     frame_sent_flag_reg;
  logic [NQ-1:0]     frame_sent_flag_next;
  logic [NQ-1:0]     frame_sent_irq_enable_reg;
  logic              ts_fifo_warn_enable_reg;
  logic              ts_fifo_update_enable_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic [DATA_W-1:0] rdata_next;
  logic [NQ-1:0]     fs_irq_reg;
  logic              warn_irq_reg;
  logic              update_irq_reg;
  logic              irq_reg;

  // Address decode
  wire sel_status  = (bus_req.addr == OFF_TX_STATUS);
  wire sel_control = (bus_req.addr == OFF_TX_CONTROL);
  wire sel_summary = (bus_req.addr == OFF_SUMMARY);
  wire wr_status   = bus_req.wr && sel_status;
  wire wr_control  = bus_req.wr && sel_control;

  // Write-zero clear strobes
  wire          sw_clr_warn   = wr_status && !bus_req.wdata[BIT_TS_WARN];
  wire          sw_clr_update = wr_status && !bus_req.wdata[BIT_TS_UPDATE];
  wire [NQ-1:0] sw_clr_frame  = {NQ{wr_status}} & ~bus_req.wdata[BIT_FRAME_HI:BIT_FRAME_LO];

  wire leave_op   = op_mode_reg && !op_mode;
  wire ts_hold_lo = !op_mode || !ts_evt.ts_fifo_enable;

  wire set_warn   = ts_evt.ts_frame_sent && ts_evt.ts_one_held;
  wire set_update = ts_evt.ts_fifo_enable && ts_evt.ts_frame_sent;

  assign ts_fifo_warn_flag_next =
    ts_hold_lo ? 1'b0 :
    set_warn   ? 1'b1 :
    sw_clr_warn ? 1'b0 : ts_fifo_warn_flag_reg;

  assign ts_fifo_update_flag_next =
    ts_hold_lo ? 1'b0 :
    set_update ? 1'b1 :
    (sw_clr_update || ts_evt.ts_fifo_release) ? 1'b0 : ts_fifo_update_flag_reg;

  // Set on link end of frame
  assign frame_sent_flag_next =
    leave_op ? RST_QUEUE : (frame_sent | (frame_sent_flag_reg & ~sw_clr_frame));

  wire [DESC_HI:DESC_LO] desc_sum =
    desc_in.desc_irq_enable_n[DESC_HI:DESC_LO] & desc_in.desc_irq_flag_n[DESC_HI:DESC_LO];
  wire ts_fifo_warn_summary   = ts_fifo_warn_enable_reg && ts_fifo_warn_flag_reg;
  wire ts_fifo_update_summary = ts_fifo_update_enable_reg && ts_fifo_update_flag_reg;

  wire [DATA_W-1:0] status_word = {22'h0, ts_fifo_warn_flag_reg,
                                   ts_fifo_update_flag_reg, 4'h0, frame_sent_flag_reg};
  wire [DATA_W-1:0] control_word = {22'h0, ts_fifo_warn_enable_reg,
                                    ts_fifo_update_enable_reg, 4'h0,
                                    frame_sent_irq_enable_reg};
  wire [DATA_W-1:0] summary_word = {desc_sum, 7'h0, ts_fifo_warn_summary,
                                    ts_fifo_update_summary, 8'h00};

  assign rdata_next = !bus_req.rd ? RST_WORD :
                      sel_status  ? status_word :
                      sel_control ? control_word :
                      sel_summary ? summary_word : RST_WORD;

  wire [NQ-1:0] fs_irq_next = frame_sent_irq_enable_reg & frame_sent_flag_reg;
  wire warn_irq_next = ts_fifo_warn_summary;
  wire irq_next = (|fs_irq_next) || warn_irq_next || ts_fifo_update_summary;

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      op_mode_reg             <= RST_BIT;
      ts_fifo_warn_flag_reg   <= RST_BIT;
      ts_fifo_update_flag_reg <= RST_BIT;
      frame_sent_flag_reg     <= RST_QUEUE;
    end else begin
      op_mode_reg             <= op_mode;
      ts_fifo_warn_flag_reg   <= ts_fifo_warn_flag_next;
      ts_fifo_update_flag_reg <= ts_fifo_update_flag_next;
      frame_sent_flag_reg     <= frame_sent_flag_next;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      frame_sent_irq_enable_reg <= RST_QUEUE;
      ts_fifo_warn_enable_reg   <= RST_BIT;
      ts_fifo_update_enable_reg <= RST_BIT;
    end else if (wr_control) begin
      frame_sent_irq_enable_reg <= bus_req.wdata[BIT_FRAME_HI:BIT_FRAME_LO];
      ts_fifo_warn_enable_reg   <= bus_req.wdata[BIT_TS_WARN];
      ts_fifo_update_enable_reg <= bus_req.wdata[BIT_TS_UPDATE];
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      rdata_reg      <= RST_WORD;
      fs_irq_reg     <= RST_QUEUE;
      warn_irq_reg   <= RST_BIT;
      update_irq_reg <= RST_BIT;
      irq_reg        <= RST_BIT;
    end else begin
      rdata_reg      <= rdata_next;
      fs_irq_reg     <= fs_irq_next;
      warn_irq_reg   <= warn_irq_next;
      update_irq_reg <= ts_fifo_update_summary;
      irq_reg        <= irq_next;
    end
  end

  assign bus_rdata      = rdata_reg;
  assign frame_sent_irq = fs_irq_reg;
  assign ts_warn_irq    = warn_irq_reg;
  assign ts_update_irq  = update_irq_reg;
  assign irq            = irq_reg;

  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  a_warn_set_event: assert property (
    (set_warn && op_mode && ts_evt.ts_fifo_enable) |=> ts_fifo_warn_flag_reg)
    else $error("warn flag not set by stamped frame");

  a_warn_hold_clear: assert property (
    ts_hold_lo |=> !ts_fifo_warn_flag_reg)
    else $error("warn flag not cleared while idle or disabled");

  a_update_set_event: assert property (
    (ts_evt.ts_frame_sent && ts_evt.ts_fifo_enable && op_mode) |=> ts_fifo_update_flag_reg)
    else $error("update flag not set");

  a_update_release_clear: assert property (
    (ts_evt.ts_fifo_release && !ts_evt.ts_frame_sent) |=> !ts_fifo_update_flag_reg)
    else $error("update flag survived release");

  a_stamp_one_ignored: assert property (
    (wr_status && bus_req.wdata[BIT_TS_WARN] && !set_warn && !ts_hold_lo)
      |=> (ts_fifo_warn_flag_reg == $past(ts_fifo_warn_flag_reg)))
    else $error("writing one changed warn flag");

  a_frame_set_event: assert property (
    (frame_sent[0] && !leave_op) ##1 (!leave_op && !wr_status)[*2]
      |-> frame_sent_flag_reg[0])
    else $error("queue flag not held after frame");

  a_frame_leave_clear: assert property (
    leave_op |=> (frame_sent_flag_reg == RST_QUEUE))
    else $error("queue flags not cleared on leaving operation");

  a_frame_one_ignored: assert property (
    (wr_status && (bus_req.wdata[BIT_FRAME_HI:BIT_FRAME_LO] == 4'hf) && !leave_op)
      |=> (frame_sent_flag_reg == ($past(frame_sent_flag_reg) | $past(frame_sent))))
    else $error("writing ones changed queue flags");

  a_status_reserved_zero: assert property (
    (bus_req.rd && sel_status) |=> ((bus_rdata[31:10] == 22'h0) &&
                                    (bus_rdata[7:4] == 4'h0)))
    else $error("reserved status bits not zero");

  a_desc_summary_read: assert property (
    (bus_req.rd && sel_summary) |=> (bus_rdata[BIT_DESC_HI:BIT_DESC_LO] ==
      $past(desc_in.desc_irq_enable_n[DESC_HI:DESC_LO] &
            desc_in.desc_irq_flag_n[DESC_HI:DESC_LO])))
    else $error("descriptor summary mismatch");

  a_queue_irq_out: assert property (
    (frame_sent_irq_enable_reg[2] && frame_sent_flag_reg[2]) |=> frame_sent_irq[2])
    else $error("queue interrupt missing");

  a_warn_irq_out: assert property (
    (ts_fifo_warn_enable_reg && ts_fifo_warn_flag_reg) |=> (ts_warn_irq && irq))
    else $error("warn interrupt missing");

  a_summary_stamp_bits: assert property (
    (bus_req.rd && sel_summary) |=>
      (bus_rdata[BIT_TS_UPDATE] == $past(ts_fifo_update_summary)) &&
      (bus_rdata[BIT_TS_WARN] == $past(ts_fifo_warn_summary)))
    else $error("stamp summary bits mismatch");

  a_set_beats_clear: assert property (
    (frame_sent[1] && wr_status && !bus_req.wdata[1] && !leave_op)
      |=> frame_sent_flag_reg[1])
    else $error("software clear beat hardware set");

  a_update_hold_clear: assert property (
    ts_hold_lo |=> !ts_fifo_update_flag_reg)
    else $error("update flag not cleared while idle or disabled");

  a_warn_no_spurious: assert property (
    (!ts_fifo_warn_flag_reg && !set_warn) |=> !ts_fifo_warn_flag_reg)
    else $error("warn flag rose without stamped frame");

  a_update_no_spurious: assert property (
    (!ts_fifo_update_flag_reg && !set_update) |=> !ts_fifo_update_flag_reg)
    else $error("update flag rose without stamped frame");

  a_warn_zero_clear: assert property (
    (wr_status && !bus_req.wdata[BIT_TS_WARN] && !set_warn) |=> !ts_fifo_warn_flag_reg)
    else $error("zero write did not clear warn flag");

  a_update_one_ignored: assert property (
    (wr_status && bus_req.wdata[BIT_TS_UPDATE] && !set_update && !ts_hold_lo &&
     !ts_evt.ts_fifo_release)
      |=> (ts_fifo_update_flag_reg == $past(ts_fifo_update_flag_reg)))
    else $error("writing one changed update flag");

  a_frame_set_all: assert property (
    !leave_op |=> ((frame_sent_flag_reg & $past(frame_sent)) == $past(frame_sent)))
    else $error("queue flag missed a sent frame");

  a_frame_no_spurious: assert property (
    ((frame_sent_flag_reg | frame_sent) == RST_QUEUE) |=> (frame_sent_flag_reg == RST_QUEUE))
    else $error("queue flag rose without frame");

  a_frame_zero_clear: assert property (
    (wr_status && (bus_req.wdata[BIT_FRAME_HI:BIT_FRAME_LO] == 4'h0) &&
     (frame_sent == RST_QUEUE)) |=> (frame_sent_flag_reg == RST_QUEUE))
    else $error("zero write did not clear queue flags");

  a_queue_irq_clear: assert property (
    !frame_sent_flag_reg[0] |=> !frame_sent_irq[0])
    else $error("queue interrupt without flag");

  a_irq_level_out: assert property (
    1'b1 |=> (irq == $past((|(frame_sent_irq_enable_reg & frame_sent_flag_reg)) ||
                           (ts_fifo_warn_enable_reg && ts_fifo_warn_flag_reg) ||
                           (ts_fifo_update_enable_reg && ts_fifo_update_flag_reg))))
    else $error("interrupt line not the or of enabled flags");

  a_warn_summary_read: assert property (
    (bus_req.rd && sel_summary) |=>
      (bus_rdata[BIT_TS_WARN] == $past(ts_fifo_warn_enable_reg && ts_fifo_warn_flag_reg)))
    else $error("warn summary bit mismatch");

  a_update_irq_out: assert property (
    (ts_fifo_update_enable_reg && ts_fifo_update_flag_reg) |=> (ts_update_irq && irq))
    else $error("update interrupt missing");

  a_summary_rsvd_zero: assert property (
    (bus_req.rd && sel_summary) |=>
      ((bus_rdata[16:10] == 7'h0) && (bus_rdata[7:0] == 8'h00)))
    else $error("unused summary bits not zero");

  c_warn_seen:   cover property (set_warn ##1 ts_fifo_warn_flag_reg);
  c_all_queues:  cover property (frame_sent_flag_reg == 4'hf);
  c_release:     cover property (ts_fifo_update_flag_reg ##1 ts_evt.ts_fifo_release);
  c_irq_raised:  cover property (!irq ##1 irq);
  c_set_clear_race: cover property (frame_sent[1] && wr_status && !bus_req.wdata[1]);

endmodule

// >>> hdl/tiss_pkg.sv
package tiss_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int NQ     = 4;
  localparam int NDESC  = 16;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFF_TX_STATUS  = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_TX_CONTROL = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_SUMMARY    = 8'h08;

  // Field positions
  localparam int BIT_TS_WARN   = 9;
  localparam int BIT_TS_UPDATE = 8;
  localparam int BIT_FRAME_LO  = 0;
  localparam int BIT_FRAME_HI  = 3;
  localparam int BIT_DESC_LO   = 17;
  localparam int BIT_DESC_HI   = 31;
  localparam int DESC_LO       = 1;
  localparam int DESC_HI       = 15;

  // Reset values
  localparam logic [DATA_W-1:0] RST_WORD  = 32'h0000_0000;
  localparam logic [NQ-1:0]     RST_QUEUE = 4'h0;
  localparam logic              RST_BIT   = 1'b0;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } tiss_bus_req_t;

  typedef struct packed {
    logic ts_frame_sent;
    logic ts_one_held;
    logic ts_fifo_enable;
    logic ts_fifo_release;
  } tiss_ts_evt_t;

  typedef struct packed {
    logic [NDESC-1:0] desc_irq_enable_n;
    logic [NDESC-1:0] desc_irq_flag_n;
  } tiss_desc_t;

endpackage

// >>> sim/tiss_mac_model.sv
`timescale 1ns/100ps
module tiss_mac_model
  import tiss_pkg::*;
(
  input  wire logic                   mclk,
  output tiss_pkg::tiss_ts_evt_t      ts_evt,
  output logic [tiss_pkg::NQ-1:0]     frame_sent,
  output tiss_pkg::tiss_desc_t        desc_in
);
  import tiss_pkg::*;
  initial begin
    ts_evt     = '0;
    frame_sent = '0;
    desc_in    = '0;
  end
  // Frame leaves the link: one-cycle pulses
  task automatic send(input logic [NQ-1:0] q, input logic stamped, input logic held);
    @(posedge mclk);
    frame_sent           <= q;
    ts_evt.ts_frame_sent <= stamped;
    ts_evt.ts_one_held   <= held;
    @(posedge mclk);
    frame_sent           <= '0;
    ts_evt.ts_frame_sent <= 1'b0;
  endtask
  task automatic set_fifo(input logic en);
    @(posedge mclk);
    ts_evt.ts_fifo_enable <= en;
  endtask
  task automatic release_fifo();
    @(posedge mclk);
    ts_evt.ts_fifo_release <= 1'b1;
    @(posedge mclk);
    ts_evt.ts_fifo_release <= 1'b0;
  endtask
  task automatic set_desc(input logic [NDESC-1:0] en, input logic [NDESC-1:0] fl);
    @(posedge mclk);
    desc_in <= '{desc_irq_enable_n: en, desc_irq_flag_n: fl};
  endtask
endmodule

// >>> sim/tiss_top_tb.sv
`timescale 1ns/100ps
module tiss_top_tb;
  import tiss_pkg::*;
  logic                mclk;
  logic                resetn;
  logic                op_mode;
  tiss_bus_req_t       bus_req;
  tiss_ts_evt_t        ts_evt;
  tiss_desc_t          desc_in;
  logic [DATA_W-1:0]   bus_rdata;
  logic [DATA_W-1:0]   rd_val;
  logic [DATA_W-1:0]   exp_st;
  logic [DATA_W-1:0]   ctrl;
  logic [DATA_W-1:0]   wd;
  logic [NQ-1:0]       frame_sent;
  logic [NQ-1:0]       frame_sent_irq;
  logic [NQ-1:0]       q;
  logic                ts_warn_irq;
  logic                ts_update_irq;
  logic                irq;
  logic [ADDR_W-1:0]   offs [4];
  int                  error_cnt;
  int                  checked;
  int                  cyc;

  tiss_top i_tiss_top (.mclk(mclk), .resetn(resetn), .bus_req(bus_req),
    .bus_rdata(bus_rdata), .op_mode(op_mode), .ts_evt(ts_evt), .frame_sent(frame_sent),
    .desc_in(desc_in), .frame_sent_irq(frame_sent_irq), .ts_warn_irq(ts_warn_irq),
    .ts_update_irq(ts_update_irq), .irq(irq));
  tiss_mac_model i_tiss_mac_model (.mclk(mclk), .ts_evt(ts_evt),
    .frame_sent(frame_sent), .desc_in(desc_in));

  always #10 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      error_cnt++;
      end_of_test();
    end
  end

  function automatic logic [31:0] sum_exp(tiss_desc_t d, logic [31:0] st, logic [31:0] c);
    sum_exp        = '0;
    sum_exp[31:17] = d.desc_irq_enable_n[15:1] & d.desc_irq_flag_n[15:1];
    sum_exp[9:8]   = st[9:8] & c[9:8];
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge mclk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    bus_req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a);
    @(posedge mclk);
    bus_req <= '{addr: a, wdata: '0, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    bus_req.rd <= 1'b0;
    @(negedge mclk);
    rd_val = bus_rdata;
    @(posedge mclk);
  endtask
  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    rd(a);
    chk(rd_val, e);
  endtask
  task automatic end_of_test();
    $display("errors %0d checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    mclk = 0; resetn = 0; op_mode = 0; bus_req = '0; cyc = 0;
    error_cnt = 0; checked = 0; exp_st = '0; ctrl = 32'h0000_030f;
    offs = '{OFF_TX_STATUS, OFF_TX_CONTROL, OFF_SUMMARY, 8'h0c};
    wd = $urandom(32'h23bd);
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    foreach (offs[i]) rd_chk(offs[i], RST_WORD);
    op_mode <= 1'b1;
    wr(OFF_TX_CONTROL, ctrl);
    rd_chk(OFF_TX_CONTROL, ctrl);
    for (int i = 0; i < 40; i++) begin
      q = NQ'($urandom);
      i_tiss_mac_model.send(q, 1'b0, 1'b0);
      exp_st[3:0] |= q;
      rd_chk(OFF_TX_STATUS, exp_st);
      @(negedge mclk);
      chk(32'(frame_sent_irq), 32'(exp_st[3:0]));
      chk(32'(irq), 32'(|exp_st[3:0]));
      wd = $urandom & 32'h0000_030f;
      wr(OFF_TX_STATUS, wd);
      exp_st &= wd;
      rd_chk(OFF_TX_STATUS, exp_st);
    end
    wr(OFF_TX_STATUS, 32'h0);
    i_tiss_mac_model.set_fifo(1'b1);
    i_tiss_mac_model.send('0, 1'b1, 1'b0);
    rd_chk(OFF_TX_STATUS, 32'h0000_0100);
    i_tiss_mac_model.send('0, 1'b1, 1'b1);
    rd_chk(OFF_TX_STATUS, 32'h0000_0300);
    @(negedge mclk);
    chk(32'({ts_warn_irq, ts_update_irq}), 32'h3);
    rd_chk(OFF_SUMMARY, sum_exp(desc_in, 32'h300, ctrl));
    wr(OFF_TX_STATUS, 32'h0000_0100);
    rd_chk(OFF_TX_STATUS, 32'h0000_0100);
    i_tiss_mac_model.release_fifo();
    rd_chk(OFF_TX_STATUS, 32'h0);
    i_tiss_mac_model.send('0, 1'b1, 1'b1);
    i_tiss_mac_model.set_fifo(1'b0);
    rd_chk(OFF_TX_STATUS, 32'h0);
    i_tiss_mac_model.set_fifo(1'b1);
    i_tiss_mac_model.send(4'hf, 1'b1, 1'b1);
    rd_chk(OFF_TX_STATUS, 32'h0000_030f);
    op_mode <= 1'b0;
    repeat (3) @(posedge mclk);
    op_mode <= 1'b1;
    rd_chk(OFF_TX_STATUS, 32'h0);
    fork
      i_tiss_mac_model.send(4'h1, 1'b0, 1'b0);
      wr(OFF_TX_STATUS, 32'h0);
    join
    rd_chk(OFF_TX_STATUS, 32'h0000_0001);
    for (int i = 0; i < 20; i++) begin
      i_tiss_mac_model.set_desc(NDESC'($urandom), NDESC'($urandom));
      wr(OFF_SUMMARY, $urandom);
      rd_chk(OFF_SUMMARY, sum_exp(desc_in, 32'h1, ctrl));
    end
    wr(OFF_TX_CONTROL, 32'h0);
    rd_chk(OFF_TX_CONTROL, 32'h0);
    @(negedge mclk);
    chk(32'(irq), 32'h0);
    end_of_test();
  end
endmodule
